/* File: logic/dad_defines.svh */
// Constants for the distance, magnitude and addition datapath.
`ifndef DAD_DEFINES_SVH
`define DAD_DEFINES_SVH
`define DAD_ADDR_CTRL 8'h00
`define DAD_ADDR_IRQ_STAT 8'h04
`define DAD_ADDR_IRQ_MASK 8'h08
`define DAD_ADDR_FLAGS 8'h0c
`define DAD_CTRL_WIDE 0
`define DAD_CTRL_DATA_UNIT_SATURATE 1
`define DAD_CTRL_ADDR_UNIT_SATURATE 2
`define DAD_CTRL_SXM 3
`define DAD_CTRL_LEGACY 4
`define DAD_CTRL_RESET 5'h08
`define DAD_EVT_DST 0
`define DAD_EVT_SRC 1
`define DAD_FLG_CARRY 2
`define DAD_MAX40 40'h7f_ffff_ffff
`define DAD_MIN40 40'h80_0000_0000
`define DAD_MAX32 40'h00_7fff_ffff
`define DAD_MIN32 40'hff_8000_0000
`define DAD_MAX16 16'h7fff
`define DAD_MIN16 16'h8000
`define DAD_HALF_SHIFT 16
`endif

/* File: logic/dad_pkg.sv */
// Types shared by the distance, magnitude and addition datapath.
`default_nettype none
package dad_pkg;
  // Operation selected by the decode stage.
  typedef enum logic [1:0] {DAD_OP_DIST, DAD_OP_MAG, DAD_OP_ADD} dad_op_t;
  // Whole state of the datapath, registered once per cycle.
  typedef struct packed {
    logic [4:0] ctrl;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic resValid;
    logic [39:0] resMain;
    logic [39:0] resAux;
    logic carry;
    logic srcOvf;
    logic dstOvf;
    logic irq;
  } dad_state_t;
endpackage
`default_nettype wire

/* File: logic/dad_alu.sv */
// Distance, magnitude and register addition datapath with an APB register file.
// Function
// - Distance does magnitude accumulate and subtraction together.
// - Magnitude accumulate overflow flags and saturates destination.
// - Subtract shifted memory operands, sign-extend to 40.
// - Subtraction carry follows wide mode; clear means borrow.
// - Subtraction overflow flags and saturates source accumulator.
// - Legacy mode drops subtraction overflow and saturation.
// - Magnitude into accumulator runs on 40 bits.
// - Narrow mode takes sign from bit 31.
// - Wide mode takes sign from bit 39.
// - Magnitude into accumulator sets carry on zero.
// - Magnitude overflow flags and saturates under data setting.
// - Magnitude into aux register runs on 16 bits.
// - 16-bit magnitude overflows at bit 15, address saturation.
// - Legacy mode runs magnitude as wide mode.
// - Addition into accumulator: 40 bits, modes apply.
// - Addition into aux register: 16 bits, bit 15.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dad_defines.svh"
module dad_alu (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic opValid,
  input wire dad_pkg::dad_op_t opCode,
  input wire logic dstIsAcc,
  input wire logic srcIsAcc,
  input wire logic [39:0] accumSrc,
  input wire logic [39:0] accumDst,
  input wire logic [15:0] memX,
  input wire logic [15:0] memY,
  output logic resValid,
  output logic [39:0] resMain,
  output logic [39:0] resAux,
  output logic carryFlag,
  output logic srcAccumOverflowFlag,
  output logic dstAccumOverflowFlag,
  output logic irq
);

  // Current and next state of the whole block.
  dad_pkg::dad_state_t st_r;
  dad_pkg::dad_state_t st_nxt;

  // Extends a 16-bit value to 40 bits, signed only when sign extension is on.
  function automatic logic [39:0] ext16(input logic [15:0] v, input logic sxm);
    ext16 = {{24{v[15] & sxm}}, v};
  endfunction

  // True when a 41-bit exact result does not fit the active accumulator width.
  function automatic logic ovf40(input logic [40:0] r, input logic wide);
    if (wide) begin
      ovf40 = r[40] ^ r[39];
    end else begin
      ovf40 = !((&r[40:31]) || (~|r[40:31]));
    end
  endfunction

  // Clamps an overflowed 41-bit result to the width at which it overflowed.
  function automatic logic [39:0] clamp40(input logic [40:0] r, input logic wide,
                                          input logic ovf, input logic sat);
    if (ovf && sat) begin
      if (wide) begin
        clamp40 = r[40] ? `DAD_MIN40 : `DAD_MAX40;
      end else begin
        clamp40 = r[40] ? `DAD_MIN32 : `DAD_MAX32;
      end
    end else begin
      clamp40 = r[39:0];
    end
  endfunction

  // Clamps a 17-bit exact result to 16 bits when the address side saturates.
  function automatic logic [15:0] clamp16(input logic [16:0] r, input logic sat);
    if ((r[16] ^ r[15]) && sat) begin
      clamp16 = r[16] ? `DAD_MIN16 : `DAD_MAX16;
    end else begin
      clamp16 = r[15:0];
    end
  endfunction

  // Outputs are plain views of registered state.
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign resValid = st_r.resValid;
  assign resMain = st_r.resMain;
  assign resAux = st_r.resAux;
  assign carryFlag = st_r.carry;
  assign srcAccumOverflowFlag = st_r.srcOvf;
  assign dstAccumOverflowFlag = st_r.dstOvf;
  assign irq = st_r.irq;

  // Next-state logic: datapath, register file and interrupt status together.
  always_comb begin
    logic wide;
    logic wideEff;
    logic data_unit_saturate;
    logic addr_unit_saturate;
    logic sxm;
    logic legacy;
    logic access;
    logic [40:0] magAcc;
    logic [40:0] diff;
    logic [39:0] opA;
    logic [39:0] opB;
    logic [39:0] src40;
    logic [16:0] r17;
    logic [15:0] s16;
    logic ovf;
    logic [1:0] evt;
    wide = st_r.ctrl[`DAD_CTRL_WIDE];
    data_unit_saturate = st_r.ctrl[`DAD_CTRL_DATA_UNIT_SATURATE];
    addr_unit_saturate = st_r.ctrl[`DAD_CTRL_ADDR_UNIT_SATURATE];
    sxm = st_r.ctrl[`DAD_CTRL_SXM];
    legacy = st_r.ctrl[`DAD_CTRL_LEGACY];
    wideEff = wide | legacy;
    access = psel && penable;
    magAcc = '0;
    diff = '0;
    opA = '0;
    opB = '0;
    src40 = srcIsAcc ? accumSrc : ext16(accumSrc[15:0], sxm);
    r17 = '0;
    s16 = '0;
    ovf = 1'b0;
    evt = 2'b00;
    st_nxt = st_r;
    st_nxt.resValid = opValid;
    st_nxt.srcOvf = 1'b0;
    st_nxt.dstOvf = 1'b0;
    if (opValid) begin
      unique case (opCode)
        dad_pkg::DAD_OP_DIST: begin
          // Magnitude of the upper part of the old source, added to the destination.
          // The magnitude reads accumSrc as presented, so the subtraction that
          // overwrites the source does not feed the magnitude in this cycle.
          opA = {{16{accumSrc[39]}}, accumSrc[39:16]};
          opB = opA[39] ? 40'(-opA) : opA;
          magAcc = {accumDst[39], accumDst} + {1'b0, opB};
          ovf = ovf40(magAcc, wide);
          st_nxt.dstOvf = ovf;
          st_nxt.resMain = clamp40(magAcc, wide, ovf, data_unit_saturate);
          // Both memory words move to the upper half before the subtraction.
          opA = ext16(memX, sxm) << `DAD_HALF_SHIFT;
          opB = ext16(memY, sxm) << `DAD_HALF_SHIFT;
          diff = {opA[39], opA} - {opB[39], opB};
          // Carry is the inverse of the borrow at the active width.
          if (wide) begin
            st_nxt.carry = !(opA < opB);
          end else begin
            st_nxt.carry = !(opA[31:0] < opB[31:0]);
          end
          // Legacy mode keeps the raw wrapped difference with no flag.
          if (legacy) begin
            st_nxt.resAux = diff[39:0];
          end else begin
            ovf = ovf40(diff, wide);
            st_nxt.srcOvf = ovf;
            st_nxt.resAux = clamp40(diff, wide, ovf, data_unit_saturate);
          end
        end
        dad_pkg::DAD_OP_MAG: begin
          st_nxt.resAux = '0;
          if (dstIsAcc) begin
            // Sign bit depends on the effective width.
            if (wideEff ? src40[39] : src40[31]) begin
              magAcc = 41'd0 - {src40[39], src40};
            end else begin
              magAcc = {src40[39], src40};
            end
            ovf = ovf40(magAcc, wideEff);
            st_nxt.dstOvf = ovf;
            st_nxt.resMain = clamp40(magAcc, wideEff, ovf, data_unit_saturate);
            st_nxt.carry = (st_nxt.resMain == 40'h00_0000_0000);
          end else begin
            // Address side sees only the low word of any source.
            s16 = accumSrc[15:0];
            r17 = s16[15] ? (17'd0 - {s16[15], s16}) : {s16[15], s16};
            st_nxt.resMain = {24'h00_0000, clamp16(r17, addr_unit_saturate)};
          end
        end
        dad_pkg::DAD_OP_ADD: begin
          st_nxt.resAux = '0;
          if (dstIsAcc) begin
            opA = accumDst;
            magAcc = {opA[39], opA} + {src40[39], src40};
            ovf = ovf40(magAcc, wide);
            st_nxt.dstOvf = ovf;
            st_nxt.resMain = clamp40(magAcc, wide, ovf, data_unit_saturate);
            if (wide) begin
              st_nxt.carry = 41'(opA + src40) > 41'h00_ffff_ffff_ff;
            end else begin
              st_nxt.carry = 33'(opA[31:0]) + 33'(src40[31:0]) > 33'h0_ffff_ffff;
            end
          end else begin
            r17 = {accumDst[15], accumDst[15:0]} + {accumSrc[15], accumSrc[15:0]};
            st_nxt.resMain = {24'h00_0000, clamp16(r17, addr_unit_saturate)};
          end
        end
        default: begin
          st_nxt.resValid = 1'b0;
        end
      endcase
    end
    // Overflow events feed the sticky interrupt status.
    evt[`DAD_EVT_DST] = st_nxt.dstOvf;
    evt[`DAD_EVT_SRC] = st_nxt.srcOvf;
    // APB: answer one cycle into the access phase, then drop ready.
    st_nxt.pready = access && !st_r.pready;
    st_nxt.pslverr = 1'b0;
    if (access && !st_r.pready) begin
      st_nxt.prdata = '0;
      unique case (paddr)
        `DAD_ADDR_CTRL: st_nxt.prdata = {27'h000_0000, st_r.ctrl};
        `DAD_ADDR_IRQ_STAT: st_nxt.prdata = {30'h0000_0000, st_r.stat};
        `DAD_ADDR_IRQ_MASK: st_nxt.prdata = {30'h0000_0000, st_r.mask};
        `DAD_ADDR_FLAGS: begin
          st_nxt.prdata = {29'h0000_0000, st_r.carry, st_r.srcOvf, st_r.dstOvf};
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    // Writes land on the edge that completes the access phase.
    if (access && st_r.pready && pwrite) begin
      if (paddr == `DAD_ADDR_CTRL) begin
        st_nxt.ctrl = pwdata[4:0];
      end
      if (paddr == `DAD_ADDR_IRQ_MASK) begin
        st_nxt.mask = pwdata[1:0];
      end
      if (paddr == `DAD_ADDR_IRQ_STAT) begin
        st_nxt.stat = st_r.stat & ~pwdata[1:0];
      end
    end
    // A new event in the same cycle as its clear still stands.
    st_nxt.stat = st_nxt.stat | evt;
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    if (srst) begin
      st_nxt = '0;
      st_nxt.ctrl = `DAD_CTRL_RESET;
    end
  end

  // Single register for the whole state.
  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  // Every operation with a defined code gives one result a cycle later.
  // The spare code is dropped on purpose, so it is kept out of the trigger.
  validPipe_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && (opCode == dad_pkg::DAD_OP_DIST || opCode == dad_pkg::DAD_OP_MAG ||
    opCode == dad_pkg::DAD_OP_ADD) |=> resValid)
    else $error("result strobe missing after operation");

  // Magnitude into an accumulator reports zero through carry.
  magZero_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opCode == dad_pkg::DAD_OP_MAG && dstIsAcc |=>
    carryFlag == (resMain == 40'h00_0000_0000))
    else $error("carry does not reflect zero magnitude");

  // A zero source gives a zero magnitude, so carry must rise.
  // This ties carry to the operands rather than to the stored result alone.
  magZeroSrc_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opCode == dad_pkg::DAD_OP_MAG && dstIsAcc && srcIsAcc &&
    accumSrc == 40'h00_0000_0000 |=> carryFlag && resMain == 40'h00_0000_0000)
    else $error("zero magnitude did not set carry");

  // Legacy subtraction never raises the source overflow flag.
  legacyNoOvf_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opCode == dad_pkg::DAD_OP_DIST && st_r.ctrl[`DAD_CTRL_LEGACY]
    |=> !srcAccumOverflowFlag)
    else $error("legacy subtraction flagged overflow");

  // A destination overflow leaves a sticky status bit behind.
  ovfSticky_a: assert property (@(posedge core_clk) disable iff (srst)
    dstAccumOverflowFlag |-> st_r.stat[`DAD_EVT_DST])
    else $error("destination overflow not latched");

  // Narrow results leave the upper bits clear.
  auxUpper_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opCode == dad_pkg::DAD_OP_MAG && !dstIsAcc |=>
    resMain[39:16] == 24'h00_0000)
    else $error("narrow magnitude touched upper bits");

  // The most negative 16-bit word saturates to the largest positive one.
  sat16_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opCode == dad_pkg::DAD_OP_MAG && !dstIsAcc &&
    st_r.ctrl[`DAD_CTRL_ADDR_UNIT_SATURATE] && accumSrc[15:0] == 16'h8000 |=>
    resMain[15:0] == 16'h7fff)
    else $error("16-bit magnitude not saturated");

  // A positive wide source passes through unchanged.
  absPos_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opCode == dad_pkg::DAD_OP_MAG && dstIsAcc && srcIsAcc &&
    st_r.ctrl[`DAD_CTRL_WIDE] && !accumSrc[39] |=> resMain == $past(accumSrc))
    else $error("positive wide source altered");

  // Equal memory operands give a zero difference and no borrow.
  distEqual_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opCode == dad_pkg::DAD_OP_DIST && memX == memY |=>
    carryFlag && resAux == 40'h00_0000_0000)
    else $error("equal operands produced borrow or nonzero result");

endmodule
`default_nettype wire

/* File: testbench/dad_fetch_model.sv */
// Model of the decode and operand fetch stages that feed the datapath.
`timescale 1ns/1ps
`default_nettype none
module dad_fetch_model (
  input wire logic core_clk,
  output logic opValid,
  output dad_pkg::dad_op_t opCode,
  output logic dstIsAcc,
  output logic srcIsAcc,
  output logic [39:0] accumSrc,
  output logic [39:0] accumDst,
  output logic [15:0] memX,
  output logic [15:0] memY
);
  // No request at time zero; operand lines carry a pattern rather than zeros.
  initial begin
    opValid = 1'b0;
    opCode = dad_pkg::DAD_OP_ADD;
    {dstIsAcc, srcIsAcc, accumSrc, accumDst, memX, memY} = {57{2'b10}};
  end
  // One request for one cycle after an idle gap of a few cycles.
  // Once taken the operands are inverted, so a late sample sees wrong data.
  task automatic issue(input logic [1:0] c, input logic [113:0] ops, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    opValid <= 1'b1;
    opCode <= dad_pkg::dad_op_t'(c);
    {dstIsAcc, srcIsAcc, accumSrc, accumDst, memX, memY} <= ops;
    @(posedge core_clk);
    opValid <= 1'b0;
    {dstIsAcc, srcIsAcc, accumSrc, accumDst, memX, memY} <= ~ops;
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_dad_alu.sv */
// Self-checking bench for the distance, magnitude and addition datapath.
`timescale 1ns/1ps
`default_nettype none
`include "dad_defines.svh"
module test_dad_alu;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, opValid, dstIsAcc, srcIsAcc;
  logic resValid, carryFlag, srcAccumOverflowFlag, dstAccumOverflowFlag, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [39:0] accumSrc, accumDst, resMain, resAux, eMain, eAux;
  logic [15:0] memX, memY;
  dad_pkg::dad_op_t opCode;
  logic [4:0] ctrlR;  // Bench copy of the mode bits.
  logic eValid, eCarry, eSrcOvf, eDstOvf;
  integer seed;
  int errCount, totalChecks;
  // Boundary operands mixed into the random stream.
  logic [39:0] corner [0:7] = '{`DAD_MIN40, `DAD_MAX40, 40'h00_8000_0000, `DAD_MIN32, 40'h0,
    40'h00_7fff_8000, 40'hff_ffff_8000, 40'h00_0000_7fff};
  dad_alu u_dut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .opValid, .opCode, .dstIsAcc, .srcIsAcc, .accumSrc, .accumDst, .memX, .memY,
    .resValid, .resMain, .resAux, .carryFlag, .srcAccumOverflowFlag, .dstAccumOverflowFlag, .irq);
  dad_fetch_model u_fetch (.core_clk, .opValid, .opCode, .dstIsAcc, .srcIsAcc, .accumSrc,
    .accumDst, .memX, .memY);
  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Every comparison goes through here so the counts stay honest.
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic giveVerdict();
    $display("checks=%0d mismatches=%0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic regIo(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] expRd, input logic expErr);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(40'(pready), 40'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    if (!wr) chk(40'(prdata), 40'(expRd));
    chk(40'(pslverr), 40'(expErr));
  endtask
  task automatic setCtrl(input logic [4:0] v);
    regIo(1'b1, 8'h00, {27'h0, v}, 32'h0, 1'b0);
    ctrlR = v;
  endtask
  // Sign or zero extension as the mode bit asks.
  function automatic logic [39:0] ext16(input logic [15:0] v);
    return ctrlR[3] ? {{24{v[15]}}, v} : {24'h0, v};
  endfunction
  // Overflow at 40 or 32 bits and the clamp; a wrapped value when saturation is off.
  task automatic fin(input logic [40:0] r, input logic w, st, ck,
                     output logic [39:0] res, output logic ov);
    ov = ck && (w ? r[40] != r[39] : !(&r[40:31] || !(|r[40:31])));
    res = (ov && st) ? (w ? (r[40] ? `DAD_MIN40 : `DAD_MAX40)
      : (r[40] ? `DAD_MIN32 : `DAD_MAX32)) : r[39:0];
  endtask
  // Works out every result of one operation from the operands and the modes.
  task automatic predict(input logic [1:0] c, input logic da, sa, input logic [39:0] s, d,
                         input logic [15:0] x, y);
    logic w, lw;
    logic [40:0] r;
    logic [39:0] src, a, b;
    logic [32:0] v;
    logic [16:0] h;
    w = ctrlR[0];
    lw = w | ctrlR[4];
    src = sa ? s : ext16(s[15:0]);
    eValid = (c != 2'd3);
    {eAux, eMain, eSrcOvf, eDstOvf} = '0;
    if (c == 2'd0) begin
      r = {{17{s[39]}}, s[39:16]};
      if (s[39]) r = -r;
      fin({d[39], d} + r, w, ctrlR[1], 1'b1, eMain, eDstOvf);
      a = ext16(x) << 16;
      b = ext16(y) << 16;
      fin({a[39], a} - {b[39], b}, w, ctrlR[1], !ctrlR[4], eAux, eSrcOvf);
      eCarry = w ? (a >= b) : (a[31:0] >= b[31:0]);
    end else if (c == 2'd1 && da) begin
      r = {src[39], src};
      if (lw ? src[39] : src[31]) r = -r;
      fin(r, lw, ctrlR[1], 1'b1, eMain, eDstOvf);
      eCarry = (eMain == 40'h0);
    end else if (c == 2'd2 && da) begin
      r = {d[39], d} + {src[39], src};
      v = {1'b0, d[31:0]} + {1'b0, src[31:0]};
      fin(r, w, ctrlR[1], 1'b1, eMain, eDstOvf);
      eCarry = w ? r[40] ^ d[39] ^ src[39] : v[32];
    end else if (eValid) begin
      h = {d[15], d[15:0]} + {s[15], s[15:0]};
      if (c == 2'd1) h = s[15] ? -{s[15], s[15:0]} : {s[15], s[15:0]};
      eMain = {24'h0, (h[16] != h[15] && ctrlR[2]) ? (h[16] ? 16'h8000 : 16'h7fff) : h[15:0]};
    end
  endtask
  // Issues one operation through the fetch model and checks the answer.
  task automatic runOp(input logic [1:0] c, input logic da, sa, input logic [39:0] s, d,
                       input logic [15:0] x, y, input int g);
    int n;
    n = 0;
    predict(c, da, sa, s, d, x, y);
    u_fetch.issue(c, {da, sa, s, d, x, y}, g);
    #1;
    while (resValid !== 1'b1 && n < 3) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(40'(resValid), 40'(eValid));
    if (eValid) begin
      chk(resMain, eMain);
      chk(resAux, eAux);
      chk(40'(carryFlag), 40'(eCarry));
      chk(40'({srcAccumOverflowFlag, dstAccumOverflowFlag}), 40'({eSrcOvf, eDstOvf}));
    end
  endtask
  function automatic logic [39:0] pick();
    logic [31:0] r;
    r = $random(seed);
    if (r[2:0] == 3'd0) return corner[r[5:3]];
    return {r[15:8], 32'($random(seed))};
  endfunction
  task automatic randOp();
    logic [31:0] r;
    logic [39:0] s, d, m;
    r = $random(seed);
    s = pick();
    d = pick();
    m = pick();
    runOp(r[1:0], r[2], r[3], s, d, m[15:0], m[31:16], int'(r[5:4]));
  endtask
  // Interrupt level must follow the status and mask a couple of edges later.
  task automatic irqIs(input logic v);
    repeat (2) @(posedge core_clk);
    #1;
    chk(40'(irq), 40'(v));
  endtask
  initial begin
    seed = 32'he121;
    {errCount, totalChecks} = '0;
    {ctrlR, eCarry, srst} = {5'h08, 1'b0, 1'b1};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) regIo(1'b0, 8'(4 * i), 32'h0, (i == 0) ? 32'h8 : 32'h0, 1'b0);
    regIo(1'b1, 8'h0c, 32'h7, 32'h0, 1'b0);
    regIo(1'b0, 8'h0c, 32'h0, 32'h0, 1'b0);
    regIo(1'b1, 8'h10, 32'h1, 32'h0, 1'b1);
    regIo(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    regIo(1'b1, 8'h00, 32'hffff_ffff, 32'h0, 1'b0);
    regIo(1'b0, 8'h00, 32'h0, 32'h1f, 1'b0);
    $display("register test done");
    // Every mode combination, each with a burst of random operations.
    for (int i = 0; i < 32; i++) begin
      setCtrl(5'(i));
      repeat (12) randOp();
    end
    $display("random test done");
    setCtrl(5'h09);
    runOp(2'd0, 1'b1, 1'b1, 40'h0, 40'h00_e800_0000, 16'h3400, 16'hef00, 2);
    chk(resAux, 40'h00_4500_0000);
    chk(40'(carryFlag), 40'h0);
    runOp(2'd1, 1'b1, 1'b1, 40'h0, 40'h0, 16'h0, 16'h0, 0);
    regIo(1'b1, 8'h04, 32'h3, 32'h0, 1'b0);
    regIo(1'b1, 8'h08, 32'h1, 32'h0, 1'b0);
    setCtrl(5'h0b);
    runOp(2'd1, 1'b1, 1'b1, `DAD_MIN40, 40'h0, 16'h0, 16'h0, 0);
    irqIs(1'b1);
    regIo(1'b0, 8'h04, 32'h0, 32'h1, 1'b0);
    regIo(1'b1, 8'h04, 32'h1, 32'h0, 1'b0);
    irqIs(1'b0);
    setCtrl(5'h0a);
    runOp(2'd0, 1'b1, 1'b1, 40'h0, 40'h0, 16'h7fff, 16'h8000, 0);
    irqIs(1'b0);
    regIo(1'b0, 8'h04, 32'h0, 32'h2, 1'b0);
    regIo(1'b1, 8'h08, 32'h3, 32'h0, 1'b0);
    irqIs(1'b1);
    regIo(1'b1, 8'h04, 32'h2, 32'h0, 1'b0);
    irqIs(1'b0);
    $display("interrupt test done");
    giveVerdict();
  end
  // Cuts a hang short well beyond the 1900 or so cycles the tests need.
  initial begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    $display("watchdog expired");
    giveVerdict();
  end
endmodule
`default_nettype wire
